//--- amx_defs.svh
`ifndef AMX_DEFS_SVH
`define AMX_DEFS_SVH

// register byte addresses
`define AMX_P1_ADDR     32'h4000_001c
`define AMX_P2_ADDR     32'h4000_0020

// select field layout
`define AMX_SEL_MSB     2
`define AMX_SEL_LSB     0
`define AMX_SEL_W       3
`define AMX_RSVD_W      29
`define AMX_SEL_RST     3'h0

// structure
`define AMX_NUM_PORTS   2
`define AMX_NUM_SRC     8
`define AMX_DATA_W      32
`define AMX_ADDR_W      32
`define AMX_SEL_BYTES   4
`define AMX_RDATA_IDLE  32'h0000_0000

`endif

//--- amx_pkg.sv
package amx_pkg;

    typedef logic [2:0] amx_sel_t;

    typedef enum logic [2:0] {
        AMX_SRC_ZERO     = 3'h0,
        AMX_SRC_SPB_CLK  = 3'h1,
        AMX_SRC_SPB_SOUT = 3'h2,
        AMX_SRC_SPB_SIN  = 3'h3,
        AMX_SRC_P2_HCLK  = 3'h4,
        AMX_SRC_SPA_SIN  = 3'h5,
        AMX_SRC_SPA_CS   = 3'h6,
        AMX_SRC_SPA_EN   = 3'h7
    } amx_src_t;

endpackage

//--- amx_mux.sv
`timescale 1ns/1ps

module amx_mux
    import amx_pkg::*;
(
    input  wire amx_sel_t   sel,
    input  wire logic [7:0] src,
    output logic            mute
);

    ////////////////////////////////////////////////////////////////////////
    // every 3-bit code is legal, so no default branch
    always_comb
    begin
        unique case (amx_src_t'(sel))
            AMX_SRC_ZERO:     mute = 1'b0;
            AMX_SRC_SPB_CLK:  mute = src[1];
            AMX_SRC_SPB_SOUT: mute = src[2];
            AMX_SRC_SPB_SIN:  mute = src[3];
            AMX_SRC_P2_HCLK:  mute = src[4];
            AMX_SRC_SPA_SIN:  mute = src[5];
            AMX_SRC_SPA_CS:   mute = src[6];
            AMX_SRC_SPA_EN:   mute = src[7];
        endcase
    end

endmodule

//--- amx_top.sv
`timescale 1ns/1ps
`include "amx_defs.svh"


module amx_top
    import amx_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`AMX_ADDR_W-1:0]   wb_adr_i,
    input  wire logic [`AMX_SEL_BYTES-1:0] wb_sel_i,
    input  wire logic [`AMX_DATA_W-1:0]   wb_dat_i,
    output logic      [`AMX_DATA_W-1:0]   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     second_spi_clock_pin,
    input  wire logic                     second_spi_slave_out_pin,
    input  wire logic                     second_spi_slave_in_pin,
    input  wire logic                     port2_rx_high_rate_clock,
    input  wire logic                     first_spi_slave_in_pin,
    input  wire logic                     first_spi_chip_select_pin,
    input  wire logic                     first_spi_enable_pin,
    output logic                          port1_mute_input,
    output logic                          port2_mute_input,
    output amx_sel_t                      port1_mute_src_sel,
    output amx_sel_t                      port2_mute_src_sel
);

    localparam int NUM_PORTS = `AMX_NUM_PORTS;

    localparam logic [`AMX_ADDR_W-1:0] PORT_ADDR [NUM_PORTS] = '{
        `AMX_P1_ADDR,
        `AMX_P2_ADDR
    };

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic                       ack_r;
    logic [`AMX_DATA_W-1:0]     rdata_r;
    logic [`AMX_DATA_W-1:0]     rdata_nxt;
    logic                       req;
    logic                       wr_req;
    logic [NUM_PORTS-1:0]       hit;
    amx_sel_t                   sel_r  [NUM_PORTS];
    logic                       mute_r [NUM_PORTS];
    logic                       mute_nxt [NUM_PORTS];
    logic [`AMX_NUM_SRC-1:0]    src_vec;

    ////////////////////////////////////////////////////////////////////////
    // source pins gathered by select code; bit 0 is the constant-zero slot

    assign src_vec = {
        first_spi_enable_pin,
        first_spi_chip_select_pin,
        first_spi_slave_in_pin,
        port2_rx_high_rate_clock,
        second_spi_slave_in_pin,
        second_spi_slave_out_pin,
        second_spi_clock_pin,
        1'b0
    };

    ////////////////////////////////////////////////////////////////////////
    // wishbone classic slave

    // new request only while no ack is up, so each access is taken once
    assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_req = req & wb_we_i;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            // unmapped addresses are acked too, so the bus never hangs
            ack_r <= req;
        end
    end

    // reserved bits and unmapped addresses read as zero
    always_comb
    begin
        rdata_nxt = `AMX_RDATA_IDLE;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (hit[i])
            begin
                rdata_nxt = {{`AMX_RSVD_W{1'b0}}, sel_r[i]};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_r <= `AMX_RDATA_IDLE;
        end
        else if (req & ~wb_we_i)
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // per-port select register, mux and registered mute output

    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port

        // full 32-bit decode keeps aliases out of the map
        assign hit[g] = (wb_adr_i == PORT_ADDR[g]);

        // only byte lane 0 carries the field; upper bits are dropped
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                sel_r[g] <= `AMX_SEL_RST;
            end
            else if (wr_req & hit[g] & wb_sel_i[0])
            begin
                sel_r[g] <= wb_dat_i[`AMX_SEL_MSB:`AMX_SEL_LSB];
            end
        end

        amx_mux u_mux (
            .sel  (sel_r[g]),
            .src  (src_vec),
            .mute (mute_nxt[g])
        );

        // one flop of latency buys a glitch-free mute output
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                mute_r[g] <= 1'b0;
            end
            else
            begin
                mute_r[g] <= mute_nxt[g];
            end
        end
    end

    assign port1_mute_input   = mute_r[0];
    assign port2_mute_input   = mute_r[1];
    assign port1_mute_src_sel = sel_r[0];
    assign port2_mute_src_sel = sel_r[1];

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    p1_route_a: assert property (
        ##1 (mute_r[0] == $past(src_vec[sel_r[0]]))
    )
    else $error("port 1 mute does not follow its selected source");

    p2_route_a: assert property (
        ##1 (mute_r[1] == $past(src_vec[sel_r[1]]))
    )
    else $error("port 2 mute does not follow its selected source");

    zero_code_a: assert property (
        (sel_r[0] == AMX_SRC_ZERO) [*2] |-> (mute_r[0] == 1'b0)
    )
    else $error("code zero did not give a zero mute input");

    spb_clk_a: assert property (
        (sel_r[1] == AMX_SRC_SPB_CLK)
        |=> (mute_r[1] == $past(second_spi_clock_pin))
    )
    else $error("code 1 did not take the second spi clock pin");

    spb_sout_a: assert property (
        (sel_r[0] == AMX_SRC_SPB_SOUT)
        |=> (mute_r[0] == $past(second_spi_slave_out_pin))
    )
    else $error("code 2 did not take the second spi slave-out pin");

    spb_sin_a: assert property (
        (sel_r[1] == AMX_SRC_SPB_SIN)
        |=> (mute_r[1] == $past(second_spi_slave_in_pin))
    )
    else $error("code 3 did not take the second spi slave-in pin");

    hclk_src_a: assert property (
        (sel_r[0] == AMX_SRC_P2_HCLK)
        |=> (mute_r[0] == $past(port2_rx_high_rate_clock))
    )
    else $error("code 4 did not take the high-rate clock pin");

    spa_sin_a: assert property (
        (sel_r[1] == AMX_SRC_SPA_SIN)
        |=> (mute_r[1] == $past(first_spi_slave_in_pin))
    )
    else $error("code 5 did not take the first spi slave-in pin");

    spi0_cs_a: assert property (
        (sel_r[0] == AMX_SRC_SPA_CS)
        |=> (mute_r[0] == $past(first_spi_chip_select_pin))
    )
    else $error("code 6 did not take the first spi select pin");

    spa_en_a: assert property (
        (sel_r[0] == AMX_SRC_SPA_EN)
        |=> (mute_r[0] == $past(first_spi_enable_pin))
    )
    else $error("code 7 did not take the first spi enable pin");

    p1_decode_a: assert property (
        (wr_req && wb_adr_i == `AMX_P1_ADDR && wb_sel_i[0])
        |=> (sel_r[0] == $past(wb_dat_i[`AMX_SEL_MSB:`AMX_SEL_LSB]))
            && $stable(sel_r[1]) && ack_r
    )
    else $error("write to port 1 address not decoded correctly");

    p2_decode_a: assert property (
        (wr_req && wb_adr_i == `AMX_P2_ADDR && wb_sel_i[0])
        |=> (sel_r[1] == $past(wb_dat_i[`AMX_SEL_MSB:`AMX_SEL_LSB]))
            && $stable(sel_r[0]) && ack_r
    )
    else $error("write to port 2 address not decoded correctly");

    rsvd_zero_a: assert property (
        ack_r |-> (wb_dat_o[`AMX_DATA_W-1:`AMX_SEL_W] == '0)
    )
    else $error("reserved read bits not zero");

    read_back_a: assert property (
        (req && !wb_we_i && wb_adr_i == `AMX_P2_ADDR)
        |=> (wb_dat_o[`AMX_SEL_MSB:`AMX_SEL_LSB] == $past(sel_r[1]))
    )
    else $error("port 2 register read back wrong");

    ack_pulse_a: assert property (
        ack_r |=> !ack_r
    )
    else $error("ack held for more than one cycle");

    reset_clear_a: assert property (
        disable iff (1'b0)
        $past(rst) |-> (sel_r[0] == `AMX_SEL_RST)
                    && (sel_r[1] == `AMX_SEL_RST)
                    && !mute_r[0] && !mute_r[1] && !ack_r
    )
    else $error("select fields or mute not cleared by reset");

    lane_gate_a: assert property (
        (wr_req && !wb_sel_i[0])
        |=> $stable(sel_r[0]) && $stable(sel_r[1])
    )
    else $error("write without byte lane 0 changed a select field");

    unmapped_wr_a: assert property (
        (wr_req && hit == '0)
        |=> $stable(sel_r[0]) && $stable(sel_r[1])
    )
    else $error("unmapped write changed a select field");

    unmapped_rd_a: assert property (
        (req && !wb_we_i && hit == '0)
        |=> (wb_dat_o == `AMX_RDATA_IDLE)
    )
    else $error("unmapped read did not return zero");

    p1_read_a: assert property (
        (req && !wb_we_i && wb_adr_i == `AMX_P1_ADDR)
        |=> (wb_dat_o[`AMX_SEL_MSB:`AMX_SEL_LSB] == $past(sel_r[0]))
    )
    else $error("port 1 register read back wrong");

    ack_answer_a: assert property (
        req |=> ack_r
    )
    else $error("request not acked in the next cycle");

    ack_idle_a: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !ack_r
    )
    else $error("ack raised without a request");

    p1_clk_src_a: assert property (
        (sel_r[0] == AMX_SRC_SPB_CLK)
        |=> (mute_r[0] == $past(second_spi_clock_pin))
    )
    else $error("port 1 code 1 did not take the second spi clock pin");

    p2_zero_a: assert property (
        (sel_r[1] == AMX_SRC_ZERO) [*2] |-> (mute_r[1] == 1'b0)
    )
    else $error("port 2 code zero did not give a zero mute input");

    ////////////////////////////////////////////////////////////////////////
    // coverage of the main scenarios

    p1_write_c: cover property (
        wr_req && hit[0] ##1 ack_r
    );

    p2_hclk_c: cover property (
        sel_r[1] == AMX_SRC_P2_HCLK ##1 mute_r[1]
    );

    unmapped_c: cover property (
        req && hit == '0 ##1 ack_r
    );

    p1_ena_c: cover property (
        sel_r[0] == AMX_SRC_SPA_EN ##1 mute_r[0]
    );

    lane_skip_c: cover property (
        wr_req && !wb_sel_i[0] ##1 ack_r
    );

endmodule

//--- amx_pin_model.sv
`timescale 1ns/1ps

// far-side pin owners: seven shared pins driven from one pattern
module amx_pin_model
(
    input  wire logic       clk,
    input  wire logic [6:0] pat,
    output logic      [6:0] pins
);
    ////////////////////////////////////////////////////////////////////////
    // pins change only on the clock, like synchronous pad levels;
    // bit k is the pin picked by select code k+1
    always_ff @(posedge clk)
    begin
        pins <= pat;
    end
endmodule

//--- test_audio_mute_input_source_mux.sv
`timescale 1ns/1ps
`include "amx_defs.svh"

module test_audio_mute_input_source_mux
    import amx_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  bsel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [6:0]  pat;
    logic [6:0]  pins;
    logic        mute1;
    logic        mute2;
    amx_sel_t    sel1;
    amx_sel_t    sel2;
    logic [31:0] got;
    logic [3:0]  be;
    logic [31:0] radr;
    int          n_errors;
    int          check_count;

    ////////////////////////////////////////////////////////////////////////
    amx_pin_model pm (.clk(clk), .pat(pat), .pins(pins));

    amx_top dut
    (
        .clk                      (clk),
        .rst                      (rst),
        .wb_cyc_i                 (cyc),
        .wb_stb_i                 (stb),
        .wb_we_i                  (we),
        .wb_adr_i                 (adr),
        .wb_sel_i                 (bsel),
        .wb_dat_i                 (wdat),
        .wb_dat_o                 (rdat),
        .wb_ack_o                 (ack),
        .second_spi_clock_pin     (pins[0]),
        .second_spi_slave_out_pin (pins[1]),
        .second_spi_slave_in_pin  (pins[2]),
        .port2_rx_high_rate_clock (pins[3]),
        .first_spi_slave_in_pin   (pins[4]),
        .first_spi_chip_select_pin(pins[5]),
        .first_spi_enable_pin     (pins[6]),
        .port1_mute_input         (mute1),
        .port2_mute_input         (mute2),
        .port1_mute_src_sel       (sel1),
        .port2_mute_src_sel       (sel2)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // classic single cycle; entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        bsel <= be;
        wdat <= d;
        // only the watchdog ends a wait for ack
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        chk("ack drop", 32'h0, {31'h0, ack});
    endtask

    // selected pin high then low, all others opposite, so a wrong pick shows
    task automatic pin_check(input int p, input logic [2:0] c);
        logic [6:0] v;
        logic       e;
        for (int k = 0; k < 2; k++)
        begin
            v = 7'h00;
            if (c != 3'h0)
                v[c - 3'h1] = 1'b1;
            if (k == 1)
                v = ~v;
            pat <= v;
            // one flop in the model plus one in the mute path
            repeat (3) @(posedge clk);
            e = (c == 3'h0) ? 1'b0 : v[c - 3'h1];
            chk("mute", {31'h0, e}, {31'h0, (p == 1) ? mute1 : mute2});
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        bsel = 4'h0;
        wdat = 32'h0;
        pat = 7'h00;
        be = 4'hf;
        radr = 32'h0;
        n_errors = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("sel reset", 32'h0, {26'h0, sel1, sel2});
        chk("mute reset", 32'h0, {30'h0, mute1, mute2});
        bus(1'b0, `AMX_P2_ADDR, 32'h0, got);
        chk("p2 read reset", 32'h0, got);
        $display("test reset done");
        // port 1 ends on code 7, so port 2's sweep also proves isolation
        for (int p = 1; p <= 2; p++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                radr = (p == 1) ? `AMX_P1_ADDR : `AMX_P2_ADDR;
                bus(1'b1, radr, {29'h0, 3'(c)}, got);
                chk("sel", {29'h0, 3'(c)}, (p == 1) ? sel1 : sel2);
                chk("other sel", (p == 1) ? 32'h0 : 32'h7,
                    (p == 1) ? sel2 : sel1);
                bus(1'b0, radr, 32'h0, got);
                chk("read back", {29'h0, 3'(c)}, got);
                pin_check(p, 3'(c));
            end
            $display("test port %0d done", p);
        end
        bus(1'b1, 32'h4000_0018, 32'h2, got);
        bus(1'b1, 32'h4000_0024, 32'h2, got);
        bus(1'b0, 32'h4000_0024, 32'h0, got);
        chk("unmapped read", `AMX_RDATA_IDLE, got);
        // byte lane 0 off: the write is acked but must not land
        be = 4'he;
        bus(1'b1, `AMX_P1_ADDR, 32'h2, got);
        be = 4'hf;
        chk("sel kept", 32'h3f, {26'h0, sel1, sel2});
        $display("test unmapped done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("sel second reset", 32'h0, {26'h0, sel1, sel2});
        chk("mute second reset", 32'h0, {30'h0, mute1, mute2});
        $display("test second reset done");
        close_out();
    end

    initial
    begin
        #50000;
        n_errors++;
        close_out();
    end
endmodule
